/* File: rscp_defines.svh */
// register map, field positions, reset values and timing counts
`ifndef RSCP_DEFINES_SVH
`define RSCP_DEFINES_SVH

`define RSCP_ADDR_W            32
`define RSCP_DATA_W            16

`define RSCP_ADDR_RADIO        32'h0500_0008
`define RSCP_ADDR_SYSCLK       32'h0500_000a
`define RSCP_ADDR_PMU          32'h5000_0010

`define RSCP_RADIO_LINK_EN     7
`define RSCP_RADIO_LP_RST      6
`define RSCP_RADIO_LINK_DIV_HI 5
`define RSCP_RADIO_LINK_DIV_LO 4
`define RSCP_RADIO_RF_EN       3
`define RSCP_RADIO_RF_DIV_HI   1
`define RSCP_RADIO_RF_DIV_LO   0

`define RSCP_SYS_ON_XTAL       7
`define RSCP_SYS_ON_RC         6
`define RSCP_SYS_ON_SLOW       5
`define RSCP_SYS_GLITCH_OFF    3
`define RSCP_SYS_XTAL_OFF      2
`define RSCP_SYS_SEL_HI        1
`define RSCP_SYS_SEL_LO        0

`define RSCP_PMU_RET_HI        11
`define RSCP_PMU_RET_LO        8
`define RSCP_PMU_BOOST         7
`define RSCP_PMU_BUCK          6

`define RSCP_RADIO_RESET       7'h20
`define RSCP_SYSC_RESET        4'h0
`define RSCP_PMU_RESET         6'h00
`define RSCP_RUN_RESET         3'h4

`define RSCP_SRC_XTAL          2'h0
`define RSCP_SRC_RC            2'h1
`define RSCP_SRC_SLOW          2'h2

`define RSCP_CLK_MHZ           40
`define RSCP_XTAL_SETTLE_US    2000
`define RSCP_SETTLE_CW         20
`define RSCP_HANDOVER_CYC      4'h4

`endif

/* File: rscp_pkg.sv */
// types shared by the radio and system clock control block
package rscp_pkg;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b001,
    ST_WAIT_SRC = 3'b010,
    ST_HANDOVER = 3'b100
  } rscp_sw_state_t;

  typedef struct packed {
    logic       linkcore_clk_en;
    logic       lowpower_timer_rst;
    logic [1:0] linkcore_clk_divider;
    logic       rf_ctrl_unit_clk_en;
    logic [1:0] rf_ctrl_unit_divider;
  } rscp_radio_t;

  typedef struct packed {
    logic       crystal_glitch_filter_off;
    logic       fast_crystal_off;
    logic [1:0] sysclk_source_select;
  } rscp_sysc_t;

  typedef struct packed {
    logic [3:0] retention_keep;
    logic       force_boost;
    logic       force_buck;
  } rscp_pmu_t;

  typedef struct packed {
    logic on_fast_crystal;
    logic on_fast_rc;
    logic on_slow_clock;
  } rscp_run_t;

endpackage

/* File: rscp_clkdiv.sv */
// clock-enable divider: one-cycle tick every 1, 2, 4 or 8 cycles
`timescale 1ns/1ps
module rscp_clkdiv (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_ce,
  input  wire logic       i_en,
  input  wire logic [1:0] i_div,
  output logic            o_tick
);

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
  } rscp_div_state_t;

  rscp_div_state_t q;
  rscp_div_state_t d;
  logic [2:0]      mask;

  always_comb begin
    d = q;
    case (i_div)
      2'h0:    mask = 3'h0;
      2'h1:    mask = 3'h1;
      2'h2:    mask = 3'h3;
      default: mask = 3'h7;
    endcase
    if (!i_en) begin
      // a disabled clock restarts cleanly on the next enable
      d.cnt  = 3'h0;
      d.tick = 1'b0;
    end else begin
      d.cnt  = q.cnt + 3'h1;
      d.tick = ((q.cnt & mask) == mask);
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_tick = q.tick;

endmodule

/* File: rscp_top.sv */
// radio clock gating, system clock source and power unit control
//
// Summary of operation
// - link core clock runs only while its enable bit is one; zero after reset.
// - low-power timer held in reset while its bit is one; one after reset.
// - link core clock divided by 1, 2, 4 or 8 from a two-bit code.
// - RF control unit clock runs only while its enable bit is one.
// - RF control unit clock divided by 1, 2, 4 or 8 from a two-bit code.
// - status bit reads one while fast crystal is system clock; one after reset.
// - status bit reads one while fast RC oscillator is system clock.
// - status bit reads one while a 32 kHz source is system clock.
// - control bit, zero after reset, bypasses the crystal clock spike filter.
// - crystal-off bit stops the crystal at once and keeps it off after wakeup.
// - source code 0 crystal, 1 fast RC, 2 or 3 slow clock.
// - four bits choose per retention RAM whether it is kept or gated.
// - force-boost bit puts the DC-DC converter in boost at next wakeup.
// - force-buck bit puts the DC-DC converter in buck at next wakeup.
// - with both force bits set, boost mode is applied.
// - after a write sets either force bit, both are locked until reset.
// - crystal-settled asserts only after more than 2 ms of crystal running.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "rscp_defines.svh"
module rscp_top #(
  parameter int unsigned SETTLE_CYC =
    `RSCP_XTAL_SETTLE_US * `RSCP_CLK_MHZ + 1
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset,
  input  wire logic                    i_ce,
  input  wire logic [`RSCP_ADDR_W-1:0] i_addr,
  input  wire logic [`RSCP_DATA_W-1:0] i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  input  wire logic                    i_sleep,
  input  wire logic                    i_wakeup,
  input  wire logic                    i_crystal_trim_done,
  output logic [`RSCP_DATA_W-1:0]      o_rdata,
  output logic                         o_linkcore_clk_ce,
  output logic                         o_rf_ctrl_unit_clk_ce,
  output logic                         o_lowpower_timer_rst,
  output logic                         o_fast_crystal_en,
  output logic                         o_crystal_glitch_filter_off,
  output logic                         o_fast_crystal_settled,
  output logic [1:0]                   o_sysclk_source,
  output logic [3:0]                   o_retention_keep,
  output logic                         o_dcdc_boost,
  output logic                         o_dcdc_buck
);

  localparam logic [`RSCP_SETTLE_CW-1:0] SETTLE_LIM =
    `RSCP_SETTLE_CW'(SETTLE_CYC);

  typedef struct packed {
    rscp_pkg::rscp_radio_t     radio;
    rscp_pkg::rscp_sysc_t      sysc;
    rscp_pkg::rscp_pmu_t       pmu;
    logic                      pmu_lock;
    rscp_pkg::rscp_sw_state_t  sw_state;
    logic [1:0]                sw_tgt;
    logic [3:0]                sw_cnt;
    logic [1:0]                cur_src;
    rscp_pkg::rscp_run_t       run;
    logic                      xtal_en;
    logic [`RSCP_SETTLE_CW-1:0] settle_cnt;
    logic                      settled;
    logic [2:0]                trim_sync;
    logic                      trim_ok;
    logic                      dcdc_boost;
    logic                      dcdc_buck;
    logic [`RSCP_DATA_W-1:0]   rdata;
  } rscp_state_t;

  rscp_state_t q;
  rscp_state_t d;
  logic        wr_radio;
  logic        wr_sys;
  logic        wr_pmu;
  logic [1:0]  tgt_src;
  logic [1:0]  div_en;
  logic [3:0]  div_code;
  logic [1:0]  div_tick;

  assign wr_radio = i_wr && (i_addr == `RSCP_ADDR_RADIO);
  assign wr_sys   = i_wr && (i_addr == `RSCP_ADDR_SYSCLK);
  assign wr_pmu   = i_wr && (i_addr == `RSCP_ADDR_PMU);

  // codes 2 and 3 both mean the slow clock
  always_comb begin
    case (q.sysc.sysclk_source_select)
      2'h0:    tgt_src = `RSCP_SRC_XTAL;
      2'h1:    tgt_src = `RSCP_SRC_RC;
      default: tgt_src = `RSCP_SRC_SLOW;
    endcase
  end

  always_comb begin
    d = q;

    // register writes
    if (wr_radio) begin
      d.radio = {i_wdata[`RSCP_RADIO_LINK_EN:`RSCP_RADIO_RF_EN],
                 i_wdata[`RSCP_RADIO_RF_DIV_HI:`RSCP_RADIO_RF_DIV_LO]};
    end
    if (wr_sys) begin
      d.sysc = i_wdata[`RSCP_SYS_GLITCH_OFF:`RSCP_SYS_SEL_LO];
    end
    if (wr_pmu) begin
      d.pmu.retention_keep =
        i_wdata[`RSCP_PMU_RET_HI:`RSCP_PMU_RET_LO];
      if (!q.pmu_lock) begin
        d.pmu.force_boost = i_wdata[`RSCP_PMU_BOOST];
        d.pmu.force_buck  = i_wdata[`RSCP_PMU_BUCK];
        // only a write that sets a force bit locks them
        d.pmu_lock = i_wdata[`RSCP_PMU_BOOST] ||
                     i_wdata[`RSCP_PMU_BUCK];
      end
    end

    // the off bit wins over any wakeup, so sleep cycles keep it off
    d.xtal_en = !d.sysc.fast_crystal_off && !i_sleep;

    // settle timer restarts whenever the crystal is stopped
    if (!d.xtal_en) begin
      d.settle_cnt = '0;
      d.settled    = 1'b0;
    end else if (q.settle_cnt != SETTLE_LIM) begin
      d.settle_cnt = q.settle_cnt + `RSCP_SETTLE_CW'(1);
      d.settled    = 1'b0;
    end else begin
      d.settled = 1'b1;
    end

    // trim-done comes from another domain: two stages must agree
    d.trim_sync = {q.trim_sync[1:0], i_crystal_trim_done};
    if (q.trim_sync[1] == q.trim_sync[2]) begin
      d.trim_ok = q.trim_sync[2];
    end

    // source switchover
    case (q.sw_state)
      rscp_pkg::ST_IDLE: begin
        if (tgt_src != q.cur_src) begin
          d.sw_tgt   = tgt_src;
          d.sw_state = rscp_pkg::ST_WAIT_SRC;
        end
      end
      rscp_pkg::ST_WAIT_SRC: begin
        // moving onto an unsettled crystal would clock the core with junk
        if (q.sw_tgt != tgt_src) begin
          d.sw_state = rscp_pkg::ST_IDLE;
        end else if (q.sw_tgt != `RSCP_SRC_XTAL ||
                     (q.xtal_en && (q.settled || q.trim_ok))) begin
          d.sw_cnt   = `RSCP_HANDOVER_CYC;
          d.sw_state = rscp_pkg::ST_HANDOVER;
        end
      end
      rscp_pkg::ST_HANDOVER: begin
        if (q.sw_tgt != tgt_src) begin
          d.sw_state = rscp_pkg::ST_IDLE;
        end else if (q.sw_cnt != 4'h0) begin
          d.sw_cnt = q.sw_cnt - 4'h1;
        end else begin
          d.cur_src = q.sw_tgt;
          d.run.on_fast_crystal = (q.sw_tgt == `RSCP_SRC_XTAL);
          d.run.on_fast_rc      = (q.sw_tgt == `RSCP_SRC_RC);
          d.run.on_slow_clock   = (q.sw_tgt == `RSCP_SRC_SLOW);
          d.sw_state = rscp_pkg::ST_IDLE;
        end
      end
      default: begin
        d.sw_state = rscp_pkg::ST_IDLE;
      end
    endcase

    // converter mode is sampled once per wakeup
    if (i_wakeup) begin
      d.dcdc_boost = q.pmu.force_boost;
      d.dcdc_buck  = q.pmu.force_buck && !q.pmu.force_boost;
    end

    // read data stand for one cycle only
    d.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        `RSCP_ADDR_RADIO: begin
          d.rdata = {8'h00, q.radio.linkcore_clk_en,
                     q.radio.lowpower_timer_rst,
                     q.radio.linkcore_clk_divider,
                     q.radio.rf_ctrl_unit_clk_en, 1'b0,
                     q.radio.rf_ctrl_unit_divider};
        end
        `RSCP_ADDR_SYSCLK: begin
          d.rdata = {8'h00, q.run, 1'b0, q.sysc};
        end
        `RSCP_ADDR_PMU: begin
          d.rdata = {4'h0, q.pmu, 6'h00};
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      q          <= '0;
      q.radio    <= `RSCP_RADIO_RESET;
      q.sysc     <= `RSCP_SYSC_RESET;
      q.pmu      <= `RSCP_PMU_RESET;
      q.sw_state <= rscp_pkg::ST_IDLE;
      q.cur_src  <= `RSCP_SRC_XTAL;
      q.run      <= `RSCP_RUN_RESET;
      q.xtal_en  <= 1'b1;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign div_en   = {q.radio.rf_ctrl_unit_clk_en, q.radio.linkcore_clk_en};
  assign div_code = {q.radio.rf_ctrl_unit_divider,
                     q.radio.linkcore_clk_divider};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_div
      rscp_clkdiv rscp_clkdiv_i (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .i_ce       (i_ce),
        .i_en       (div_en[gi]),
        .i_div      (div_code[2*gi +: 2]),
        .o_tick     (div_tick[gi])
      );
    end
  endgenerate

  assign o_linkcore_clk_ce           = div_tick[0];
  assign o_rf_ctrl_unit_clk_ce       = div_tick[1];
  assign o_rdata                     = q.rdata;
  assign o_lowpower_timer_rst        = q.radio.lowpower_timer_rst;
  assign o_fast_crystal_en           = q.xtal_en;
  assign o_crystal_glitch_filter_off = q.sysc.crystal_glitch_filter_off;
  assign o_fast_crystal_settled      = q.settled;
  assign o_sysclk_source             = q.cur_src;
  assign o_retention_keep            = q.pmu.retention_keep;
  assign o_dcdc_boost                = q.dcdc_boost;
  assign o_dcdc_buck                 = q.dcdc_buck;

  AST_LINK_GATED: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_ce && !q.radio.linkcore_clk_en) |=> !o_linkcore_clk_ce)
    else $error("link core clock ticked while disabled");

  AST_RF_GATED: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_ce && !q.radio.rf_ctrl_unit_clk_en) |=> !o_rf_ctrl_unit_clk_ce)
    else $error("rf unit clock ticked while disabled");

  AST_LINK_DIV8: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_ce && o_linkcore_clk_ce && q.radio.linkcore_clk_en &&
     q.radio.linkcore_clk_divider == 2'h3) ##1
    (i_ce && q.radio.linkcore_clk_divider == 2'h3)[*7]
    |-> !$past(o_linkcore_clk_ce, 6))
    else $error("link core divide by eight ticked early");

  AST_LP_RST: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_ce && wr_radio) |=>
    (o_lowpower_timer_rst == $past(i_wdata[`RSCP_RADIO_LP_RST])))
    else $error("low-power timer reset does not follow its bit");

  AST_XTAL_OFF: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_ce && wr_sys && i_wdata[`RSCP_SYS_XTAL_OFF]) |=>
    !o_fast_crystal_en && !o_fast_crystal_settled ##1 !o_fast_crystal_settled)
    else $error("crystal still enabled after off bit set");

  AST_RUN_ONEHOT: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    $onehot(q.run) && (q.run.on_fast_crystal == (q.cur_src == 2'h0)))
    else $error("clock source status not one-hot or not current");

  AST_SRC_DONE: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_ce && q.sw_state == rscp_pkg::ST_HANDOVER && q.sw_cnt == 4'h0 &&
     q.sw_tgt == tgt_src) |=> (o_sysclk_source == $past(q.sw_tgt)))
    else $error("source switch did not complete");

  AST_SETTLE: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    $rose(o_fast_crystal_settled) |->
    (q.settle_cnt == SETTLE_LIM) && $past(o_fast_crystal_en))
    else $error("crystal reported settled too early");

  AST_BOOST_WINS: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_ce && i_wakeup && q.pmu.force_boost) |=>
    o_dcdc_boost && !o_dcdc_buck)
    else $error("boost did not take precedence at wakeup");

  AST_PMU_LOCK: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (q.pmu_lock && i_ce && wr_pmu) |=>
    $stable(q.pmu.force_boost) && $stable(q.pmu.force_buck))
    else $error("force bits changed after lock");

  AST_RET: assert property (
    @(posedge i_core_clk) disable iff (i_reset)
    (i_ce && wr_pmu) |=>
    (o_retention_keep == $past(i_wdata[`RSCP_PMU_RET_HI:`RSCP_PMU_RET_LO])))
    else $error("retention selection not applied");

endmodule

/* File: rscp_top_test.sv */
// self-checking register-level bench for the radio and system clock control
`timescale 1ns/1ps
`include "rscp_defines.svh"
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
  err_count++; $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
  end end
module rscp_top_test;
  logic        i_core_clk;
  logic        i_reset;
  logic        i_ce;
  logic [31:0] i_addr;
  logic [15:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic        i_sleep;
  logic        i_wakeup;
  logic        i_crystal_trim_done;
  logic [15:0] o_rdata;
  logic        o_linkcore_clk_ce;
  logic        o_rf_ctrl_unit_clk_ce;
  logic        o_lowpower_timer_rst;
  logic        o_fast_crystal_en;
  logic        o_crystal_glitch_filter_off;
  logic        o_fast_crystal_settled;
  logic [1:0]  o_sysclk_source;
  logic [3:0]  o_retention_keep;
  logic        o_dcdc_boost;
  logic        o_dcdc_buck;
  int          err_count;
  int          checks;
  int          cyc;
  localparam int SETTLE = 20;

  rscp_top #(.SETTLE_CYC(SETTLE)) rscp_top_i (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_sleep(i_sleep), .i_wakeup(i_wakeup),
    .i_crystal_trim_done(i_crystal_trim_done), .o_rdata(o_rdata),
    .o_linkcore_clk_ce(o_linkcore_clk_ce),
    .o_rf_ctrl_unit_clk_ce(o_rf_ctrl_unit_clk_ce),
    .o_lowpower_timer_rst(o_lowpower_timer_rst),
    .o_fast_crystal_en(o_fast_crystal_en),
    .o_crystal_glitch_filter_off(o_crystal_glitch_filter_off),
    .o_fast_crystal_settled(o_fast_crystal_settled),
    .o_sysclk_source(o_sysclk_source), .o_retention_keep(o_retention_keep),
    .o_dcdc_boost(o_dcdc_boost), .o_dcdc_buck(o_dcdc_buck));

  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ceiling is over thirty times the expected run so slow switchovers still fit
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic reset_dut;
    @(posedge i_core_clk);
    i_reset <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_reset <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic chk_rd(input string nm, input logic [31:0] a,
                        input logic [15:0] exp);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(nm, exp, o_rdata)
  endtask

  task automatic count_ticks(output int nl, output int nr);
    nl = 0;
    nr = 0;
    repeat (64) begin
      @(posedge i_core_clk);
      #1;
      if (o_linkcore_clk_ce === 1'b1) nl++;
      if (o_rf_ctrl_unit_clk_ce === 1'b1) nr++;
    end
  endtask

  task automatic wait_src(input logic [1:0] s);
    int n;
    n = 0;
    while (o_sysclk_source !== s && n < 200) begin
      @(posedge i_core_clk);
      #1;
      n++;
    end
    `CHK("source", s, o_sysclk_source)
  endtask

  task automatic pulse_wakeup;
    @(posedge i_core_clk);
    i_wakeup <= 1'b1;
    @(posedge i_core_clk);
    i_wakeup <= 1'b0;
    #1;
  endtask

  task automatic pmu_case(input logic [15:0] d, input logic eb,
                          input logic eu);
    reset_dut();
    wr(`RSCP_ADDR_PMU, d | 16'h0a00);
    `CHK("retention", 4'ha, o_retention_keep)
    wr(`RSCP_ADDR_PMU, 16'h00c0 & ~d);
    wr(`RSCP_ADDR_PMU, 16'h0000);
    chk_rd("pmu locked", `RSCP_ADDR_PMU, d & 16'h00c0);
    `CHK("boost early", 1'b0, o_dcdc_boost)
    pulse_wakeup();
    `CHK("boost", eb, o_dcdc_boost)
    `CHK("buck", eu, o_dcdc_buck)
  endtask

  initial begin
    int nl;
    int nr;
    logic [15:0] st;
    logic [15:0] old;
    logic [1:0] sel;
    err_count = 0;
    checks = 0;
    cyc = 0;
    i_reset = 1'b1;
    i_ce = 1'b1;
    i_addr = 32'h0000_0000;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_sleep = 1'b0;
    i_wakeup = 1'b0;
    i_crystal_trim_done = 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_reset <= 1'b0;
    #1;
    `CHK("lp rst out", 1'b1, o_lowpower_timer_rst)
    `CHK("xtal en", 1'b1, o_fast_crystal_en)
    chk_rd("radio rst", `RSCP_ADDR_RADIO, 16'h0040);
    chk_rd("sys rst", `RSCP_ADDR_SYSCLK, 16'h0080);
    chk_rd("pmu rst", `RSCP_ADDR_PMU, 16'h0000);
    $display("test reset values done");

    // link and rf dividers run opposite codes so a swapped field shows
    for (int d = 0; d < 4; d++) begin
      wr(`RSCP_ADDR_RADIO,
         16'h0088 | 16'(d << 4) | 16'(3 - d));
      `CHK("lp rst low", 1'b0, o_lowpower_timer_rst)
      repeat (16) @(posedge i_core_clk);
      count_ticks(nl, nr);
      `CHK("link ticks", 64 >> d, nl)
      `CHK("rf ticks", 64 >> (3 - d), nr)
    end
    // a write while the clock enable is low must leave the register alone
    @(posedge i_core_clk);
    i_ce <= 1'b0;
    wr(`RSCP_ADDR_RADIO, 16'h0040);
    @(posedge i_core_clk);
    i_ce <= 1'b1;
    chk_rd("ce frozen", `RSCP_ADDR_RADIO, 16'h00b8);
    wr(`RSCP_ADDR_RADIO, 16'hff40);
    chk_rd("radio rb", `RSCP_ADDR_RADIO, 16'h0040);
    count_ticks(nl, nr);
    `CHK("link off", 0, nl)
    `CHK("rf off", 0, nr)
    wr(32'h0500_0009, 16'hffff);
    chk_rd("unmapped wr", `RSCP_ADDR_RADIO, 16'h0040);
    chk_rd("unmapped rd", 32'h0500_0009, 16'h0000);
    $display("test dividers done");

    old = 16'h0080;
    for (int k = 0; k < 4; k++) begin
      sel = 2'((k + 1) % 4);
      st = (sel == 2'h0) ? 16'h0080 : (sel == 2'h1) ? 16'h0040 : 16'h0020;
      // status bits and reserved bits written as ones must not stick
      wr(`RSCP_ADDR_SYSCLK, 16'hfff0 | 16'(sel));
      chk_rd("status hold", `RSCP_ADDR_SYSCLK, old | 16'(sel));
      wait_src((sel == 2'h3) ? 2'h2 : sel);
      repeat (2) @(posedge i_core_clk);
      chk_rd("status", `RSCP_ADDR_SYSCLK, st | 16'(sel));
      old = st;
    end
    wr(`RSCP_ADDR_SYSCLK, 16'h0008);
    `CHK("glitch off", 1'b1, o_crystal_glitch_filter_off)
    wr(`RSCP_ADDR_SYSCLK, 16'h0000);
    `CHK("glitch on", 1'b0, o_crystal_glitch_filter_off)
    $display("test source switch done");

    // crystal may only be stopped while the system runs from another source
    wr(`RSCP_ADDR_SYSCLK, 16'h0002);
    wait_src(2'h2);
    wr(`RSCP_ADDR_SYSCLK, 16'h0006);
    @(posedge i_core_clk);
    #1;
    `CHK("xtal stop", 1'b0, o_fast_crystal_en)
    @(posedge i_core_clk);
    i_sleep <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    i_sleep <= 1'b0;
    pulse_wakeup();
    repeat (3) @(posedge i_core_clk);
    #1;
    `CHK("xtal wake", 1'b0, o_fast_crystal_en)
    `CHK("settled lost", 1'b0, o_fast_crystal_settled)
    wr(`RSCP_ADDR_SYSCLK, 16'h0002);
    repeat (2) @(posedge i_core_clk);
    #1;
    `CHK("xtal back", 1'b1, o_fast_crystal_en)
    // trim-done alone lets the crystal be chosen before it has settled
    @(posedge i_core_clk);
    i_crystal_trim_done <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    wr(`RSCP_ADDR_SYSCLK, 16'h0000);
    wait_src(2'h0);
    `CHK("settle early", 1'b0, o_fast_crystal_settled)
    repeat (SETTLE) @(posedge i_core_clk);
    #1;
    `CHK("settled", 1'b1, o_fast_crystal_settled)
    repeat (2) @(posedge i_core_clk);
    chk_rd("on xtal", `RSCP_ADDR_SYSCLK, 16'h0080);
    $display("test crystal done");

    pmu_case(16'h0080, 1'b1, 1'b0);
    pmu_case(16'h0040, 1'b0, 1'b1);
    pmu_case(16'h00c0, 1'b1, 1'b0);
    $display("test power unit done");
    stop_test();
  end
endmodule
